// >>> binary_adder_carry_overflow.v
// Notes on behaviour
// RULE1: Add instructions form a plain unsigned 16-bit sum of two words.
// RULE2: A carry out of bit 15 writes one into the carry latch.
// RULE3: Without a carry out of bit 15 the add leaves the latch unchanged.
// RULE4: Overflow is the exclusive-OR of carries out of bits 14 and 15.
// RULE5: An overflow during an add sets the range error flag to one.
// RULE6: The carry latch is never fed into the add as carry input.
// RULE7: Skip-on-set and skip-on-clear test the carry latch for chaining.
// RULE8: Firmware heeds overflow on the top word, carry on the others.
// RULE9: Negate works on one accumulator word only, with no carry linkage.
// RULE10: Overflow detection only watches; sum and carry are unchanged by it.
// RULE11: Invert flips every accumulator bit; negate gives inverted plus one.
// RULE12: Sum, carry latch and range flag all update in one instruction.
`timescale 1ns/1ps
`include "adder_defines.vh"
module binary_adder_carry_overflow #(
  parameter W = `WORD_W
) (
  input  wire         clock,
  input  wire         resetn,
  input  wire         clk_en,
  input  wire         op_valid,
  input  wire [3:0]   op_code,
  input  wire [W-1:0] operand,
  output reg  [W-1:0] acc_a_ff,
  output reg  [W-1:0] acc_b_ff,
  output reg          carry_latch_ff,
  output reg          range_error_flag_ff,
  output reg          skip_ff,
  output reg          done_ff
);
  reg  [W-1:0] nxt_acc_a;
  reg  [W-1:0] nxt_acc_b;
  reg          nxt_carry_latch;
  reg          nxt_range_error_flag;
  reg          nxt_skip;
  reg          nxt_done;
  reg  [W-1:0] add_lhs;
  reg  [W-1:0] add_rhs;
  reg          add_cin;
  wire [W-1:0] add_sum;
  wire         carry_hi;
  wire         carry_lo;
  wire         is_add;
  wire         is_add_a;
  wire         is_add_b;
  wire         is_neg_a;
  wire         is_neg_b;
  wire         add_carry;
  wire         add_range;

  assign is_add_a = (op_code == `OP_ADD_A);
  assign is_add_b = (op_code == `OP_ADD_B);
  assign is_neg_a = (op_code == `OP_NEG_A);
  assign is_neg_b = (op_code == `OP_NEG_B);
  assign is_add   = is_add_a | is_add_b;

  // Flags only watch the adder; they never steer the sum.
  assign add_carry = op_valid & is_add & carry_hi; // see RULE2
  assign add_range = op_valid & is_add &
                     (carry_hi ^ carry_lo); // see RULE4 see RULE10

  // One shared adder serves both add and negate.
  always @* begin
    add_lhs = acc_a_ff;
    add_rhs = operand;
    add_cin = 1'b0; // see RULE6
    if (is_add_b) begin
      add_lhs = acc_b_ff;
    end else if (is_neg_a) begin
      add_lhs = ~acc_a_ff; // see RULE11
      add_rhs = {W{1'b0}};
      add_cin = 1'b1; // see RULE9
    end else if (is_neg_b) begin
      add_lhs = ~acc_b_ff; // see RULE11
      add_rhs = {W{1'b0}};
      add_cin = 1'b1; // see RULE9
    end
  end

  // The adder splits off the top bit so both top carries are visible.
  word_adder #(
    .W (W)
  ) u_adder (
    .opa      (add_lhs),
    .opb      (add_rhs),
    .cin      (add_cin),
    .sum      (add_sum), // see RULE1
    .carry_hi (carry_hi),
    .carry_lo (carry_lo)
  );

  // Accumulator A takes the sum, its inverse or a loaded word.
  always @* begin
    nxt_acc_a = acc_a_ff;
    if (op_valid) begin
      case (op_code)
        `OP_ADD_A: begin
          nxt_acc_a = add_sum; // see RULE12
        end
        `OP_NEG_A: begin
          nxt_acc_a = add_sum; // see RULE11
        end
        `OP_INV_A: begin
          nxt_acc_a = ~acc_a_ff; // see RULE11
        end
        `OP_LOAD_A: begin
          nxt_acc_a = operand;
        end
        default: begin
          nxt_acc_a = acc_a_ff;
        end
      endcase
    end
  end

  // Accumulator B takes the sum, its inverse or a loaded word.
  always @* begin
    nxt_acc_b = acc_b_ff;
    if (op_valid) begin
      case (op_code)
        `OP_ADD_B: begin
          nxt_acc_b = add_sum; // see RULE12
        end
        `OP_NEG_B: begin
          nxt_acc_b = add_sum; // see RULE11
        end
        `OP_INV_B: begin
          nxt_acc_b = ~acc_b_ff; // see RULE11
        end
        `OP_LOAD_B: begin
          nxt_acc_b = operand;
        end
        default: begin
          nxt_acc_b = acc_b_ff;
        end
      endcase
    end
  end

  // The carry latch is sticky; only its clear operation lowers it.
  always @* begin
    nxt_carry_latch = carry_latch_ff; // see RULE3
    if (op_valid && (op_code == `OP_CLR_CARRY)) begin
      nxt_carry_latch = 1'b0;
    end
    if (add_carry) begin
      nxt_carry_latch = 1'b1; // see RULE2
    end
  end

  // The range error flag is sticky; only its clear operation lowers it.
  always @* begin
    nxt_range_error_flag = range_error_flag_ff;
    if (op_valid && (op_code == `OP_CLR_RANGE)) begin
      nxt_range_error_flag = 1'b0;
    end
    if (add_range) begin
      nxt_range_error_flag = 1'b1; // see RULE5
    end
  end

  // A skip answers for one cycle whether the tested latch state holds.
  always @* begin
    nxt_skip = 1'b0;
    nxt_done = op_valid;
    if (op_valid && (op_code == `OP_SKIP_SET)) begin
      nxt_skip = carry_latch_ff; // see RULE7
    end else if (op_valid && (op_code == `OP_SKIP_CLR)) begin
      nxt_skip = ~carry_latch_ff; // see RULE7
    end
  end

  // Every register holds its value while the clock enable is low.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_a_ff <= `ACC_RESET;
    end else if (clk_en) begin
      acc_a_ff <= nxt_acc_a;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_b_ff <= `ACC_RESET;
    end else if (clk_en) begin
      acc_b_ff <= nxt_acc_b;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      carry_latch_ff <= 1'b0;
    end else if (clk_en) begin
      carry_latch_ff <= nxt_carry_latch;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      range_error_flag_ff <= 1'b0;
    end else if (clk_en) begin
      range_error_flag_ff <= nxt_range_error_flag;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skip_ff <= 1'b0;
    end else if (clk_en) begin
      skip_ff <= nxt_skip;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= nxt_done;
    end
  end
endmodule

// >>> adder_defines.vh
`ifndef ADDER_DEFINES_VH
`define ADDER_DEFINES_VH
`define WORD_W          16
`define SIGN_BIT        15
`define OP_NONE         4'h0
`define OP_ADD_A        4'h1
`define OP_ADD_B        4'h2
`define OP_NEG_A        4'h3
`define OP_NEG_B        4'h4
`define OP_INV_A        4'h5
`define OP_INV_B        4'h6
`define OP_SKIP_SET     4'h7
`define OP_SKIP_CLR     4'h8
`define OP_CLR_CARRY    4'h9
`define OP_CLR_RANGE    4'hA
`define OP_LOAD_A       4'hB
`define OP_LOAD_B       4'hC
`define ACC_RESET       16'h0000
`endif

// >>> word_adder.v
`timescale 1ns/1ps
`include "adder_defines.vh"
module word_adder #(
  parameter W = `WORD_W
) (
  input  wire [W-1:0] opa,
  input  wire [W-1:0] opb,
  input  wire         cin,
  output wire [W-1:0] sum,
  output wire         carry_hi,
  output wire         carry_lo
);
  wire [W-1:0] low_sum;

  // The upper bit is added apart so the carry out of the bit below is seen.
  assign low_sum = {1'b0, opa[W-2:0]} + {1'b0, opb[W-2:0]} +
                   {{(W-1){1'b0}}, cin};
  assign carry_lo = low_sum[W-1];
  assign carry_hi = (opa[W-1] & opb[W-1]) |
                    (carry_lo & (opa[W-1] ^ opb[W-1]));
  assign sum = {opa[W-1] ^ opb[W-1] ^ carry_lo, low_sum[W-2:0]};
endmodule

// >>> adder_checker.sv
`timescale 1ns/1ps
module adder_checker #(
  parameter W = 16
) (
  input wire         clock,
  input wire         resetn,
  input wire         clk_en,
  input wire         op_valid,
  input wire [3:0]   op_code,
  input wire [W-1:0] operand,
  input wire [W-1:0] acc_a_ff,
  input wire [W-1:0] acc_b_ff,
  input wire         carry_latch_ff,
  input wire         range_error_flag_ff,
  input wire         skip_ff,
  input wire         done_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire         go = op_valid & clk_en;
  wire         ad = go && op_code == 4'h1;
  wire [W:0]   s  = acc_a_ff + operand;
  wire         v  = ~(acc_a_ff[W-1] ^ operand[W-1]) &
                    (s[W-1] ^ acc_a_ff[W-1]);
  chk_add_sum: assert property (ad |=> acc_a_ff == $past(s[W-1:0]))
    else $error("add sum wrong");
  chk_carry_set: assert property (ad && s[W] |=> carry_latch_ff)
    else $error("carry not set");
  chk_carry_keep: assert property (ad && !s[W] |=>
    $stable(carry_latch_ff)) else $error("carry changed");
  chk_range_set: assert property (ad && v |=> range_error_flag_ff)
    else $error("range flag not set");
  chk_range_keep: assert property (ad && !v |=> $stable(range_error_flag_ff))
    else $error("range flag changed");
  chk_negate_one: assert property (go && op_code == 4'h3 |=>
    acc_a_ff == -$past(acc_a_ff) && $stable(acc_b_ff)) else $error("negate wrong");
  chk_invert_acc: assert property (go && op_code == 4'h5 |=>
    acc_a_ff == ~$past(acc_a_ff)) else $error("invert wrong");
  chk_skip_set: assert property (go && op_code == 4'h7 |=>
    skip_ff == $past(carry_latch_ff)) else $error("skip wrong");
  chk_done_pulse: assert property (go |=> done_ff)
    else $error("done missing");
  cover property (ad && v);
  cover property (ad && s[W]);
  cover property (go && op_code == 4'h8 ##1 !skip_ff);
endmodule
bind binary_adder_carry_overflow adder_checker #(.W(W)) u_chk (.clock, .resetn,
  .clk_en, .op_valid, .op_code, .operand, .acc_a_ff, .acc_b_ff,
  .carry_latch_ff, .range_error_flag_ff, .skip_ff, .done_ff);

// >>> seq_pace.sv
`timescale 1ns/1ps
module seq_pace (
  input  wire clock,
  input  wire slow,
  output reg  clk_en = 1'b1
);
  // Slow mode lets every other edge pass unused.
  always @(posedge clock) begin
    clk_en <= !slow | !clk_en;
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg          clock = 1'b0;
  reg          resetn = 1'b0;
  reg          slow = 1'b0;
  reg          op_valid = 1'b0;
  reg  [3:0]   op_code = 4'h0;
  reg  [15:0]  operand = 16'h0000;
  wire         clk_en, carry_latch_ff, range_error_flag_ff, skip_ff, done_ff;
  wire [15:0]  acc_a_ff, acc_b_ff;
  integer      mismatches = 0;
  integer      n_compared = 0;
  always #5 clock = ~clock;
  seq_pace pace (.clock, .slow, .clk_en);
  binary_adder_carry_overflow dut (.clock, .resetn, .clk_en, .op_valid,
    .op_code, .operand, .acc_a_ff, .acc_b_ff, .carry_latch_ff,
    .range_error_flag_ff, .skip_ff, .done_ff);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task op(input [3:0] c, input [15:0] d);
    begin
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= c;
      operand <= d;
      @(posedge clock);
      while (!clk_en) @(posedge clock);
      op_valid <= 1'b0;
      #1;
    end
  endtask
  task t_add(input [15:0] a, input [15:0] b);
    reg [16:0] s;
    begin
      s = a + b;
      op(4'h9, 16'h0000);
      op(4'hA, 16'h0000);
      op(4'hB, a);
      op(4'h1, b);
      chk(acc_a_ff, s[15:0]);
      chk(carry_latch_ff, s[16]);
      chk(range_error_flag_ff, a[15] == b[15] && s[15] != a[15]);
      chk(done_ff, 16'h0001);
    end
  endtask
  task t_chain;
    begin
      op(4'h7, 16'h0000);
      chk(skip_ff, 16'h0001);
      op(4'h8, 16'h0000);
      chk(skip_ff, 16'h0000);
      op(4'hC, 16'h0002);
      op(4'h2, 16'h0001);
      chk(acc_b_ff, 16'h0003);
      chk(carry_latch_ff, 16'h0001);
    end
  endtask
  task t_neg;
    begin
      op(4'hB, 16'h1234);
      op(4'h3, 16'h0000);
      chk(acc_a_ff, 16'hEDCC);
      op(4'h5, 16'h0000);
      chk(acc_a_ff, 16'h1233);
      op(4'h4, 16'h0000);
      chk(acc_b_ff, 16'hFFFD);
      chk(acc_a_ff, 16'h1233);
      op(4'h6, 16'h0000);
      chk(acc_b_ff, 16'h0002);
    end
  endtask
  task t_multi;
    begin
      op(4'h9, 16'h0000);
      op(4'hC, 16'h0001);
      op(4'hB, 16'hFFFF);
      op(4'h1, 16'h0001);
      op(4'h7, 16'h0000);
      chk(skip_ff, 16'h0001);
      if (skip_ff) op(4'h2, 16'h0001);
      op(4'h2, 16'h0002);
      chk(acc_b_ff, 16'h0004);
      chk(acc_a_ff, 16'h0000);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_add(16'h7FFF, 16'h0001);
    t_add(16'h8000, 16'h8000);
    slow <= 1'b1;
    t_add(16'hFFFF, 16'h0001);
    t_chain;
    t_neg;
    t_multi;
    report_and_stop;
  end
  initial begin
    #20000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule
